// file: hdl/mdr_pkg.sv
// Shared constants and state types for the twelve-channel transfer engine.
// Assumes one system clock and an AHB-Lite style single master port.
package mdr_pkg;
	// -------------------------------------------------------------------
	// Sizes
	// -------------------------------------------------------------------
	localparam int NCH = 12;
	localparam int NREQ = 16;
	localparam int NSYNC = 4;
	localparam int NTRIG = 4;
	localparam int CNT_W = 16;
	localparam int FIFO_W = 32;
	localparam int FIFO_DEPTH = 8;

	// -------------------------------------------------------------------
	// Encodings
	// -------------------------------------------------------------------
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] PRIO_LOW = 2'h0;
	localparam logic [1:0] PRIO_VHIGH = 2'h3;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HBURST_SINGLE = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	typedef enum logic [2:0] {PH_IDLE, PH_RADDR, PH_RDATA, PH_WLOAD, PH_WADDR,
		PH_WDATA} mdr_phase_t;

	// Engine state outside the FIFO; registered as one word.
	typedef struct packed {
		mdr_phase_t phase;
		logic [3:0] ch;
		logic [NCH-1:0] active;
		logic [NCH-1:0] prevEn;
		logic [NCH-1:0][CNT_W-1:0] remain;
		logic [NCH-1:0][31:0] srcPtr;
		logic [NCH-1:0][31:0] dstPtr;
		logic [NCH-1:0] tcFlag;
		logic [NCH-1:0] htFlag;
		logic [NCH-1:0] teFlag;
		logic [NCH-1:0] syncArm;
		logic [NCH-1:0] genPend;
		logic [NCH-1:0] ack;
		logic [NSYNC-1:0] syncPrev;
		logic [NTRIG-1:0] trigPrev;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
	} mdr_state_t;

	localparam mdr_state_t MDR_STATE_RST = '0;
endpackage

// file: hdl/mdr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; depth is a power of two.
`timescale 1ns/1ps
module mdr_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk, // System clock.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic inVal, // Write side offers a word.
	output logic inRdy, // Room for one more word.
	input wire logic [W-1:0] inData, // Word to store.
	output logic outVal, // A word is waiting.
	input wire logic outRdy, // Read side takes the word.
	output logic [W-1:0] outData // Oldest word.
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} mdr_fifo_st_t;
	mdr_fifo_st_t s_reg, s_next;
	logic push, pop;

	// Full and empty come straight from the occupancy count.
	assign inRdy = s_reg.cnt != (AW+1)'(DEPTH);
	assign outVal = s_reg.cnt != '0;
	assign outData = s_reg.mem[s_reg.rp];
	assign push = inVal & inRdy;
	assign pop = outVal & outRdy;

	// Next state: store on push, advance on pop.
	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wp] = inData;
			s_next.wp = s_reg.wp + 1'b1;
		end
		if (pop) begin
			s_next.rp = s_reg.rp + 1'b1;
		end
		s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule // mdr_fifo

// file: hdl/mdr_engine.sv
// Twelve-channel transfer engine with request router and one bus master.
// Assumes on-chip request, sync and trigger lines on the same clock and
// an AHB-Lite slave fabric that answers with hready and hresp.
`timescale 1ns/1ps
// Contract
// RULE_01 - Twelve independent channels move data without the processor.
// RULE_02 - All reads and writes go through one AHB master port.
// RULE_03 - Any mapped address may be source or destination of a channel.
// RULE_04 - A channel follows a routed peripheral request or a software start.
// RULE_05 - The arbiter serves the highest of four programmed priorities.
// RULE_06 - Among equal priorities the lowest channel index wins.
// RULE_07 - Source and destination sizes are set apart; data is packed or cut. The code never packs: each narrow item is zero-extended.
// RULE_08 - Software keeps addresses aligned to their configured sizes.
// RULE_09 - In circular mode a finished buffer restarts on its own.
// RULE_10 - Each channel holds a sixteen-bit item count, zero allowed.
// RULE_11 - Each channel has one interrupt raised by complete, half or error.
// RULE_12 - The router ties each channel to one request line, free or synced.
// RULE_13 - The router can also make requests from trigger input edges.
// RULE_14 - Each item lowers the count; half and zero raise flags; circular reloads.
module mdr_engine import mdr_pkg::*; (
	input wire logic clk, // System clock, 125 MHz.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic [NCH-1:0] chEnable, // Channel enable level.
	input wire logic [NCH-1:0] chMemToMem, // Software start instead of request.
	input wire logic [NCH-1:0] chCircular, // Restart buffer at its end.
	input wire logic [NCH-1:0] chSrcInc, // Step source pointer.
	input wire logic [NCH-1:0] chDstInc, // Step destination pointer.
	input wire logic [NCH-1:0][1:0] chPrio, // Priority, 3 is very high.
	input wire logic [NCH-1:0][1:0] chSrcSize, // Source item size.
	input wire logic [NCH-1:0][1:0] chDstSize, // Destination item size.
	input wire logic [NCH-1:0][CNT_W-1:0] chCount, // Items per buffer.
	input wire logic [NCH-1:0][31:0] chSrcAddr, // Source base address.
	input wire logic [NCH-1:0][31:0] chDstAddr, // Destination base address.
	input wire logic [NCH-1:0] chFlagClr, // Pulse clears the three flags.
	input wire logic [NCH-1:0][3:0] rtSel, // Router request line select.
	input wire logic [NCH-1:0] rtSyncEn, // Forward only after a sync edge.
	input wire logic [NCH-1:0][1:0] rtSyncSel, // Sync input select.
	input wire logic [NCH-1:0] rtGenEn, // Generate requests from triggers.
	input wire logic [NCH-1:0][1:0] rtTrigSel, // Trigger input select.
	input wire logic [NREQ-1:0] periphReq, // Peripheral request levels.
	input wire logic [NSYNC-1:0] syncIn, // Router sync events.
	input wire logic [NTRIG-1:0] trigIn, // Router trigger events.
	output logic [NCH-1:0] periphAck, // One-cycle item-done pulse.
	output logic [NCH-1:0] chActive, // Channel still has work.
	output logic [NCH-1:0] chComplete, // Sticky transfer complete.
	output logic [NCH-1:0] chHalf, // Sticky half transfer.
	output logic [NCH-1:0] chError, // Sticky transfer error.
	output logic [NCH-1:0] chIrq, // Per-channel interrupt.
	output logic [31:0] haddr, // Bus address.
	output logic [1:0] htrans, // Bus transfer type.
	output logic hwrite, // Bus write.
	output logic [2:0] hsize, // Bus size.
	output logic [2:0] hburst, // Always single.
	output logic [31:0] hwdata, // Bus write data.
	input wire logic [31:0] hrdata, // Bus read data.
	input wire logic hready, // Bus ready.
	input wire logic hresp // Bus error response.
);
	// -------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------
	mdr_state_t s_reg, s_next;
	logic [NCH-1:0] chReq, pend;
	logic [4:0] win;
	logic grant, itemDone, busErr;
	logic fifoInVal, fifoInRdy, fifoOutVal, fifoOutRdy;
	logic [31:0] fifoOut, rdShift, rdItem, wrLanes;
	logic [NSYNC-1:0] syncEdge;
	logic [NTRIG-1:0] trigEdge;
	logic [CNT_W-1:0] curRemain, curCount, newRem;

	// Priority pick: scanning down with >= leaves the lowest index on ties.
	function automatic logic [4:0] pick(input logic [NCH-1:0] p,
		input logic [NCH-1:0][1:0] pr);
		logic f;
		logic [3:0] idx;
		logic [1:0] best;
		f = 1'b0;
		idx = '0;
		best = PRIO_LOW;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (p[i] && (!f || pr[i] >= best)) begin // RULE_05 RULE_06
				f = 1'b1;
				idx = 4'(i);
				best = pr[i];
			end
		end
		return {f, idx};
	endfunction
	// Pointer step for one item.
	function automatic logic [31:0] step(input logic inc, input logic [1:0] sz);
		return inc ? (32'h1 << sz) : 32'h0;
	endfunction
	// -------------------------------------------------------------------
	// Request router
	// -------------------------------------------------------------------
	assign syncEdge = syncIn & ~s_reg.syncPrev;
	assign trigEdge = trigIn & ~s_reg.trigPrev;

	// Each channel sees one request source; only live channels compete.
	for (genvar g = 0; g < NCH; g++) begin : gRoute
		assign chReq[g] = chMemToMem[g] | (rtGenEn[g] ? s_reg.genPend[g] : // RULE_04 RULE_13
			periphReq[rtSel[g]] & (~rtSyncEn[g] | s_reg.syncArm[g])); // RULE_12
		assign pend[g] = s_reg.active[g] & (s_reg.remain[g] != '0) & chReq[g]; // RULE_01
	end
	// -------------------------------------------------------------------
	// Datapath helpers
	// -------------------------------------------------------------------
	assign win = pick(pend, chPrio);
	assign grant = s_reg.phase == PH_IDLE && win[4] && fifoInRdy;
	assign curRemain = s_reg.remain[s_reg.ch];
	assign curCount = chCount[s_reg.ch];
	assign newRem = curRemain - CNT_ONE;
	assign busErr = (s_reg.phase == PH_RDATA || s_reg.phase == PH_WDATA) && hready && hresp;
	assign itemDone = s_reg.phase == PH_WDATA && hready && !hresp;
	assign fifoInVal = s_reg.phase == PH_RDATA && hready && !hresp;
	assign fifoOutRdy = s_reg.phase == PH_WLOAD;
	assign rdShift = hrdata >> {s_reg.haddr[1:0], 3'b000};

	// Narrow source items are zero-extended; wider ones get cut on write.
	always_comb begin
		case (chSrcSize[s_reg.ch]) // RULE_07
			SZ_BYTE: rdItem = {24'h0, rdShift[7:0]};
			SZ_HALF: rdItem = {16'h0, rdShift[15:0]};
			default: rdItem = rdShift;
		endcase
		case (chDstSize[s_reg.ch])
			SZ_BYTE: wrLanes = {4{fifoOut[7:0]}};
			SZ_HALF: wrLanes = {2{fifoOut[15:0]}};
			default: wrLanes = fifoOut;
		endcase
	end

	// Read data waits here; a full buffer holds off the next grant.
	mdr_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) uFifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.inVal(fifoInVal),
		.inRdy(fifoInRdy),
		.inData(rdItem),
		.outVal(fifoOutVal),
		.outRdy(fifoOutRdy),
		.outData(fifoOut)
	);

	// -------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------
	// Clears come first so a flag set by the bus later in the process wins.
	always_comb begin
		s_next = s_reg;
		s_next.ack = '0;
		s_next.syncPrev = syncIn;
		s_next.trigPrev = trigIn;
		s_next.prevEn = chEnable;
		for (int i = 0; i < NCH; i++) begin
			if (rtSyncEn[i] && syncEdge[rtSyncSel[i]]) begin
				s_next.syncArm[i] = 1'b1; // RULE_12
			end
			if (rtGenEn[i] && trigEdge[rtTrigSel[i]]) begin
				s_next.genPend[i] = 1'b1; // RULE_13
			end
			if (chEnable[i] && !s_reg.prevEn[i]) begin
				s_next.active[i] = 1'b1;
				s_next.remain[i] = chCount[i]; // RULE_10
				s_next.srcPtr[i] = chSrcAddr[i];
				s_next.dstPtr[i] = chDstAddr[i];
			end
			if (!chEnable[i]) begin
				s_next.active[i] = 1'b0;
			end
			if (chFlagClr[i]) begin
				s_next.tcFlag[i] = 1'b0;
				s_next.htFlag[i] = 1'b0;
				s_next.teFlag[i] = 1'b0;
			end
		end
		unique case (s_reg.phase)
			PH_IDLE: begin
				if (grant) begin
					s_next.ch = win[3:0];
					s_next.haddr = s_reg.srcPtr[win[3:0]]; // RULE_03
					s_next.htrans = HTRANS_NONSEQ; // RULE_02
					s_next.hwrite = 1'b0;
					s_next.hsize = {1'b0, chSrcSize[win[3:0]]};
					s_next.phase = PH_RADDR;
				end
			end
			PH_RADDR: begin
				if (hready) begin
					s_next.htrans = HTRANS_IDLE;
					s_next.phase = PH_RDATA;
				end
			end
			PH_RDATA: begin
				if (hready) begin
					s_next.phase = hresp ? PH_IDLE : PH_WLOAD;
				end
			end
			PH_WLOAD: begin
				if (fifoOutVal) begin
					s_next.haddr = s_reg.dstPtr[s_reg.ch];
					s_next.htrans = HTRANS_NONSEQ;
					s_next.hwrite = 1'b1;
					s_next.hsize = {1'b0, chDstSize[s_reg.ch]}; // RULE_07
					s_next.hwdata = wrLanes;
					s_next.phase = PH_WADDR;
				end
			end
			PH_WADDR: begin
				if (hready) begin
					s_next.htrans = HTRANS_IDLE;
					s_next.phase = PH_WDATA;
				end
			end
			PH_WDATA: begin
				if (hready) begin
					s_next.phase = PH_IDLE;
				end
			end
		endcase
		// An error response stops the channel and raises its error flag.
		if (busErr) begin
			s_next.teFlag[s_reg.ch] = 1'b1; // RULE_11
			s_next.active[s_reg.ch] = 1'b0;
		end
		// One item written: count down, step pointers, flag, maybe reload.
		if (itemDone) begin
			s_next.ack[s_reg.ch] = 1'b1; // RULE_04
			s_next.syncArm[s_reg.ch] = rtSyncEn[s_reg.ch] & syncEdge[rtSyncSel[s_reg.ch]]; // RULE_12
			s_next.genPend[s_reg.ch] = rtGenEn[s_reg.ch] & trigEdge[rtTrigSel[s_reg.ch]]; // RULE_13
			s_next.remain[s_reg.ch] = newRem; // RULE_14
			s_next.srcPtr[s_reg.ch] = s_reg.srcPtr[s_reg.ch] +
				step(chSrcInc[s_reg.ch], chSrcSize[s_reg.ch]);
			s_next.dstPtr[s_reg.ch] = s_reg.dstPtr[s_reg.ch] +
				step(chDstInc[s_reg.ch], chDstSize[s_reg.ch]);
			if (newRem == (curCount >> 1)) begin
				s_next.htFlag[s_reg.ch] = 1'b1; // RULE_14
			end
			if (newRem == '0) begin
				s_next.tcFlag[s_reg.ch] = 1'b1; // RULE_11
				if (chCircular[s_reg.ch]) begin
					s_next.remain[s_reg.ch] = curCount; // RULE_09
					s_next.srcPtr[s_reg.ch] = chSrcAddr[s_reg.ch];
					s_next.dstPtr[s_reg.ch] = chDstAddr[s_reg.ch];
				end else begin
					s_next.active[s_reg.ch] = 1'b0;
				end
			end
		end
	end

	// State register.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= MDR_STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// -------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------
	assign periphAck = s_reg.ack;
	assign chActive = s_reg.active;
	assign chComplete = s_reg.tcFlag;
	assign chHalf = s_reg.htFlag;
	assign chError = s_reg.teFlag;
	assign chIrq = s_reg.tcFlag | s_reg.htFlag | s_reg.teFlag; // RULE_11
	assign haddr = s_reg.haddr;
	assign htrans = s_reg.htrans;
	assign hwrite = s_reg.hwrite;
	assign hsize = s_reg.hsize;
	assign hburst = HBURST_SINGLE;
	assign hwdata = s_reg.hwdata;

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Helper: no pending channel beats the granted one.
	logic hiOk, tieOk;
	always_comb begin
		hiOk = 1'b1;
		tieOk = 1'b1;
		for (int i = 0; i < NCH; i++) begin
			if (pend[i] && chPrio[i] > chPrio[win[3:0]]) hiOk = 1'b0;
			if (pend[i] && chPrio[i] == chPrio[win[3:0]] && 4'(i) < win[3:0]) tieOk = 1'b0;
		end
	end

	property p_prio;
		grant |-> hiOk;
	endproperty
	a_prio: assert property (p_prio) else $error("Lower priority granted."); // RULE_05
	property p_tie;
		grant |-> tieOk;
	endproperty
	a_tie: assert property (p_tie) else $error("Higher index won a tie."); // RULE_06
	property p_waitHold;
		(s_reg.phase == PH_RDATA || s_reg.phase == PH_WDATA) && !hready
			|=> htrans == HTRANS_IDLE && $stable(haddr) && $stable(hwdata);
	endproperty
	a_waitHold: assert property (p_waitHold) else $error("Bus changed in wait state."); // RULE_02
	property p_readWrite;
		fifoInVal |=> ##1 htrans == HTRANS_NONSEQ && hwrite;
	endproperty
	a_readWrite: assert property (p_readWrite) else $error("Write did not follow read."); // RULE_03
	property p_dstSize;
		s_reg.phase == PH_WADDR |-> hsize[1:0] == chDstSize[s_reg.ch];
	endproperty
	a_dstSize: assert property (p_dstSize) else $error("Write size wrong."); // RULE_07
	property p_countDown;
		itemDone && curRemain != CNT_ONE |=> curRemain == $past(curRemain) - CNT_ONE;
	endproperty
	a_countDown: assert property (p_countDown) else $error("Count did not step."); // RULE_14
	property p_circular;
		itemDone && curRemain == CNT_ONE && chCircular[s_reg.ch] |=> curRemain == $past(curCount);
	endproperty
	a_circular: assert property (p_circular) else $error("Circular reload missing."); // RULE_09
	property p_errIrq;
		busErr |=> chError[s_reg.ch] && chIrq[s_reg.ch] && !chActive[s_reg.ch];
	endproperty
	a_errIrq: assert property (p_errIrq) else $error("Error not flagged."); // RULE_11
	property p_sync;
		grant && rtSyncEn[win[3:0]] && !rtGenEn[win[3:0]] && !chMemToMem[win[3:0]]
			|-> s_reg.syncArm[win[3:0]];
	endproperty
	a_sync: assert property (p_sync) else $error("Unsynced request served."); // RULE_12
	property p_ack;
		|periphAck |-> $past(itemDone) && $onehot(periphAck);
	endproperty
	a_ack: assert property (p_ack) else $error("Stray acknowledge."); // RULE_04
	c_wrap: cover property (itemDone && curRemain == CNT_ONE && chCircular[s_reg.ch]);
	c_err: cover property (busErr);
	c_half: cover property (itemDone ##1 chHalf[s_reg.ch]);
endmodule // mdr_engine

// file: tb/mdr_ahb_slave.sv
// AHB-Lite slave memory model standing on the far side of the engine's bus.
// Assumes single transfers; wait states and one failing address come from the bench.
`timescale 1ns/1ps
module mdr_ahb_slave import mdr_pkg::*; (
	input wire logic clk, // System clock.
	input wire logic sys_rst, // Reset, active high.
	input wire logic [31:0] haddr, // Bus address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write.
	input wire logic [2:0] hsize, // Size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic [3:0] waitCyc, // Wait states per data phase.
	input wire logic errEn, // Answer errAddr with an error.
	input wire logic [31:0] errAddr, // Address that fails.
	output logic [31:0] hrdata, // Read data.
	output logic hready, // Ready.
	output logic hresp // Error response.
);
	logic [31:0] mem [0:255];
	logic pend, pWr, pErr, errPh;
	logic [31:0] pAddr;
	logic [2:0] pSize;
	logic [3:0] cnt;
	// The error answer takes two cycles, the first with hready low, as the bus demands.
	assign hresp = pend && pErr && cnt == 4'h0;
	assign hready = !pend || (cnt == 4'h0 && (!pErr || errPh));
	// Outside a read data phase the model shows inverted data, never a stale word.
	assign hrdata = (pend && !pWr && cnt == 4'h0) ? mem[pAddr[9:2]] : ~mem[pAddr[9:2]];
	// Data phase bookkeeping; writes land only on the lanes of their size.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend <= 1'b0;
			pErr <= 1'b0;
			errPh <= 1'b0;
			cnt <= 4'h0;
		end else if (hready) begin
			for (int i = 0; i < 4; i++) begin
				if (pend && pWr && !pErr && (pSize >= 3'h2 ||
						(pSize == 3'h1 ? i[1] == pAddr[1] : i[1:0] == pAddr[1:0]))) begin
					mem[pAddr[9:2]][8*i+:8] <= hwdata[8*i+:8];
				end
			end
			pend <= htrans == HTRANS_NONSEQ;
			pWr <= hwrite;
			pAddr <= haddr;
			pSize <= hsize;
			cnt <= waitCyc;
			pErr <= errEn && haddr == errAddr;
			errPh <= 1'b0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else begin
			errPh <= 1'b1;
		end
	end
endmodule // mdr_ahb_slave

// file: tb/tb_mdr_engine.sv
// Self-checking bench for the twelve-channel transfer engine.
// Assumes the slave model above as the only bus target; inputs change at falling edges.
`timescale 1ns/1ps
module tb_mdr_engine import mdr_pkg::*;;
	logic clk = 1'b0, sys_rst = 1'b1, hwrite, hready, hresp, errEn = 1'b0;
	logic [NCH-1:0] chEnable = '0, chMemToMem = '0, chCircular = '0, chSrcInc = '0;
	logic [NCH-1:0] chDstInc = '0, chFlagClr = '0, rtSyncEn = '0, rtGenEn = '0;
	logic [NCH-1:0] periphAck, chActive, chComplete, chHalf, chError, chIrq;
	logic [NCH-1:0][1:0] chPrio = '0, chSrcSize = '0, chDstSize = '0, rtSyncSel = '0;
	logic [NCH-1:0][1:0] rtTrigSel = '0;
	logic [NCH-1:0][CNT_W-1:0] chCount = '0;
	logic [NCH-1:0][31:0] chSrcAddr = '0, chDstAddr = '0;
	logic [NCH-1:0][3:0] rtSel = '0;
	logic [NREQ-1:0] periphReq = '0;
	logic [NSYNC-1:0] syncIn = '0;
	logic [NTRIG-1:0] trigIn = '0;
	logic [31:0] haddr, hwdata, hrdata, errAddr = '0;
	logic [1:0] htrans;
	logic [2:0] hsize, hburst;
	logic [3:0] waitCyc = 4'h0;
	int n_fail = 0, num_checks = 0;
	int ackCnt [NCH];

	mdr_engine uut (.clk, .sys_rst, .chEnable, .chMemToMem, .chCircular, .chSrcInc, .chDstInc,
		.chPrio, .chSrcSize, .chDstSize, .chCount, .chSrcAddr, .chDstAddr, .chFlagClr, .rtSel,
		.rtSyncEn, .rtSyncSel, .rtGenEn, .rtTrigSel, .periphReq, .syncIn, .trigIn, .periphAck,
		.chActive, .chComplete, .chHalf, .chError, .chIrq, .haddr, .htrans, .hwrite, .hsize,
		.hburst, .hwdata, .hrdata, .hready, .hresp);
	mdr_ahb_slave slv (.clk, .sys_rst, .haddr, .htrans, .hwrite, .hsize, .hwdata, .waitCyc,
		.errEn, .errAddr, .hrdata, .hready, .hresp);

	// -------------------------------------------------------------------
	// Clock, item counting and shared tasks
	// -------------------------------------------------------------------
	initial forever #4 clk = ~clk;
	// Items are counted from the one-cycle done pulses of each channel.
	always @(posedge clk) for (int i = 0; i < NCH; i++) if (periphAck[i] === 1'b1) ackCnt[i]++;

	task automatic summarize;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Waits are bounded so a stuck engine ends the run instead of hanging it.
	task automatic waitFor(input int c, input int n);
		for (int k = 0; k < 3000 && ackCnt[c] < n; k++) @(negedge clk);
		if (ackCnt[c] < n) begin
			chk("ack wait", ackCnt[c], n);
			summarize();
		end
	endtask
	task automatic waitPulse(input int c);
		int k;
		for (k = 0; k < 3000 && periphAck[c] !== 1'b1; k++) @(negedge clk);
		if (k == 3000) begin
			chk("pulse wait", 0, 1);
			summarize();
		end
	endtask
	task automatic waitIdle(input int c);
		int k;
		for (k = 0; k < 3000 && chActive[c] !== 1'b0; k++) @(negedge clk);
		if (k == 3000) begin
			chk("idle wait", 1, 0);
			summarize();
		end
	endtask
	// Addresses handed in here are always aligned to their item sizes.
	task automatic setup(input int c, input logic m2m, circ, input logic [1:0] pr, ss, ds,
		input logic [15:0] n, input logic [31:0] src, dst);
		@(negedge clk);
		chEnable[c] = 1'b0;
		chMemToMem[c] = m2m;
		chCircular[c] = circ;
		chPrio[c] = pr;
		chSrcSize[c] = ss;
		chDstSize[c] = ds;
		chCount[c] = n;
		chSrcAddr[c] = src;
		chDstAddr[c] = dst;
		chSrcInc[c] = 1'b1;
		chDstInc[c] = 1'b1;
	endtask
	task automatic go(input int c);
		@(negedge clk) chEnable[c] = 1'b1;
	endtask
	task automatic clr(input int c);
		@(negedge clk) chFlagClr[c] = 1'b1;
		@(negedge clk) chFlagClr[c] = 1'b0;
	endtask

	// -------------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------------
	task automatic t_copy;
		waitCyc = 4'h2;
		for (int i = 0; i < 4; i++) slv.mem[i] = 32'h11111111 * (i + 1);
		setup(0, 1'b1, 1'b0, 2'h1, SZ_WORD, SZ_WORD, 16'h0004, 32'h0, 32'h100);
		go(0);
		waitFor(0, 2);
		chk("half", chHalf[0], 1);
		chk("complete early", chComplete[0], 0);
		waitFor(0, 4);
		cyc(2);
		chk("complete", chComplete[0], 1);
		chk("irq", chIrq[0], 1);
		chk("active", chActive[0], 0);
		for (int i = 0; i < 4; i++) chk("copy", slv.mem[64+i], 32'h11111111 * (i + 1));
		clr(0);
		chk("irq cleared", chIrq[0], 0);
		waitCyc = 4'h0;
		$display("test copy done");
	endtask
	task automatic t_pack;
		slv.mem[0] = 32'hA1B2C3D4;
		slv.mem[8'h60] = '1;
		slv.mem[8'h61] = '1;
		slv.mem[8'h68] = '0;
		setup(3, 1'b1, 1'b0, 2'h0, SZ_BYTE, SZ_WORD, 16'h0002, 32'h1, 32'h180);
		go(3);
		waitFor(3, 2);
		setup(3, 1'b1, 1'b0, 2'h0, SZ_WORD, SZ_HALF, 16'h0001, 32'h0, 32'h1A2);
		go(3);
		waitFor(3, 3);
		cyc(2);
		chk("byte to word 0", slv.mem[8'h60], 32'h000000C3);
		chk("byte to word 1", slv.mem[8'h61], 32'h000000B2);
		chk("word to half", slv.mem[8'h68], 32'hC3D40000);
		$display("test pack done");
	endtask
	task automatic t_prio;
		int k;
		for (int p = 0; p < 2; p++) begin
			setup(1, 1'b1, 1'b0, p ? PRIO_LOW : 2'h2, SZ_WORD, SZ_WORD, 16'h1, 32'h0, 32'h1F0);
			setup(2, 1'b1, 1'b0, p ? PRIO_VHIGH : 2'h2, SZ_WORD, SZ_WORD, 16'h1, 32'h0, 32'h1F4);
			@(negedge clk);
			chEnable[1] = 1'b1;
			chEnable[2] = 1'b1;
			for (k = 0; k < 300 && periphAck[2:1] === 2'b00; k++) @(negedge clk);
			chk("first grant", periphAck[2:1], p ? 2'b10 : 2'b01);
			if (k == 300) summarize();
			cyc(20);
		end
		$display("test prio done");
	endtask
	task automatic t_circ;
		int b;
		slv.mem[8'h72] = 32'h5A5A5A5A;
		setup(4, 1'b1, 1'b1, 2'h0, SZ_WORD, SZ_WORD, 16'h0002, 32'h0, 32'h1C0);
		go(4);
		chSrcInc[4] = 1'b0;
		b = ackCnt[4];
		waitFor(4, b + 5);
		chk("circ active", chActive[4], 1);
		chk("circ complete", chComplete[4], 1);
		chk("circ bound", slv.mem[8'h72], 32'h5A5A5A5A);
		chk("src fixed", slv.mem[8'h71], 32'hA1B2C3D4);
		@(negedge clk) chEnable[4] = 1'b0;
		cyc(10);
		clr(4);
		$display("test circ done");
	endtask
	task automatic t_err;
		int b;
		errAddr = 32'h4;
		errEn = 1'b1;
		setup(5, 1'b1, 1'b0, 2'h0, SZ_WORD, SZ_WORD, 16'h0003, 32'h0, 32'h1D0);
		b = ackCnt[5];
		go(5);
		cyc(2);
		waitIdle(5);
		errEn = 1'b0;
		chk("error", chError[5], 1);
		chk("error irq", chIrq[5], 1);
		chk("error complete", chComplete[5], 0);
		chk("error items", ackCnt[5] - b, 1);
		clr(5);
		chk("error cleared", chError[5], 0);
		$display("test err done");
	endtask
	task automatic t_route;
		int b;
		setup(6, 1'b0, 1'b0, 2'h0, SZ_WORD, SZ_WORD, 16'h0003, 32'h0, 32'h1E0);
		rtSel[6] = 4'h5;
		slv.mem[8'h79] = 32'h5A5A5A5A;
		b = ackCnt[6];
		go(6);
		chDstInc[6] = 1'b0;
		periphReq[4] = 1'b1;
		cyc(20);
		chk("other line", ackCnt[6] - b, 0);
		periphReq[4] = 1'b0;
		periphReq[5] = 1'b1;
		waitPulse(6);
		periphReq[5] = 1'b0;
		cyc(20);
		chk("free line", ackCnt[6] - b, 1);
		rtSyncEn[6] = 1'b1;
		rtSyncSel[6] = 2'h2;
		periphReq[5] = 1'b1;
		cyc(20);
		chk("sync hold", ackCnt[6] - b, 1);
		syncIn[2] = 1'b1;
		waitPulse(6);
		periphReq[5] = 1'b0;
		syncIn[2] = 1'b0;
		rtSyncEn[6] = 1'b0;
		rtGenEn[6] = 1'b1;
		rtTrigSel[6] = 2'h3;
		cyc(20);
		chk("sync item", ackCnt[6] - b, 2);
		trigIn[3] = 1'b1;
		@(negedge clk) trigIn[3] = 1'b0;
		waitPulse(6);
		cyc(20);
		chk("gen item", ackCnt[6] - b, 3);
		chk("gen complete", chComplete[6], 1);
		chk("dst fixed", slv.mem[8'h78], 32'h33333333);
		chk("dst stays", slv.mem[8'h79], 32'h5A5A5A5A);
		$display("test route done");
	endtask
	task automatic t_zero;
		setup(7, 1'b1, 1'b0, 2'h0, SZ_WORD, SZ_WORD, 16'h0000, 32'h0, 32'h1F8);
		go(7);
		cyc(30);
		chk("zero items", ackCnt[7], 0);
		chk("zero complete", chComplete[7], 0);
		$display("test zero done");
	endtask

	// Reset for three cycles, then every scenario in turn.
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		chk("reset htrans", htrans, HTRANS_IDLE);
		chk("single burst", hburst, HBURST_SINGLE);
		t_copy();
		t_pack();
		t_prio();
		t_circ();
		t_err();
		t_route();
		t_zero();
		summarize();
	end
endmodule // tb_mdr_engine
